// ===== hdl/pwm_map.svh
// Register offsets, field positions and reset values of the four-channel PWM block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
`define CH_STRIDE 8'h10
`define OFF_START 8'h00
`define OFF_FLIP 8'h04
`define OFF_COUNT 8'h08
`define OFF_SETUP 8'h40
`define SETUP_EN_LSB 0
`define SETUP_CLK_LSB 4
`define SETUP_PHASE_LSB 8
`define START_RESET 10'h000
`define FLIP_RESET 10'h200
`define SETUP_RESET 12'h000
`define COUNT_MAX 10'h3ff
`define PRESCALE_DIV 8
`endif

// ===== hdl/pwm_pkg.sv
// Types shared by the PWM block.
// Assumes pwm_map.svh supplies the numeric constants.
package pwm_pkg;
  typedef logic [9:0] count_t;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage

// ===== hdl/pwm_channel.sv
// One PWM channel: counter, reload and output toggling.
// Assumes a single clock domain and a tick pulse for counting.
`timescale 1ns/1ns
`include "pwm_map.svh"
module pwm_channel
  import pwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic tick,
  input wire logic invert,
  input wire count_t start_count,
  input wire count_t flip_point,
  output count_t count_q,
  output logic wave_q
);
  logic run_q;
  logic level_q;

  // Counter loads the start value when enabled, then counts and reloads after the top.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= 10'h000;
      run_q <= 1'b0;
    end else if (ce) begin
      run_q <= enable;
      if (!enable || !run_q) begin
        count_q <= start_count;
      end else if (tick) begin
        if (count_q == `COUNT_MAX) begin
          count_q <= start_count;
        end else begin
          count_q <= count_q + 10'h001;
        end
      end
    end
  end

  // Level starts low at each load and flips where the count meets the flip point.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level_q <= 1'b0;
    end else if (ce) begin
      if (!enable || !run_q || (tick && count_q == `COUNT_MAX)) begin
        level_q <= 1'b0;
      end else if (tick && count_q == flip_point) begin
        level_q <= ~level_q;
      end
    end
  end

  // Phase select inverts the output; a disabled channel idles low.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wave_q <= 1'b0;
    end else if (ce) begin
      wave_q <= enable & (level_q ^ invert);
    end
  end

  flip_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && enable && run_q && tick && count_q == flip_point && count_q != `COUNT_MAX
    |=> level_q != $past(level_q)) else $error("level did not flip at flip point");
  reload_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && enable && run_q && tick && count_q == `COUNT_MAX
    |=> count_q == $past(start_count)) else $error("counter did not reload");
  step_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && enable && run_q && tick && count_q != `COUNT_MAX
    |=> count_q == $past(count_q) + 10'h001) else $error("counter did not step");
  idle_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && !enable ##1 ce && !enable |=> !wave_q) else $error("disabled output not low");
  wrap_c: cover property (@(posedge core_clk) disable iff (rst)
    enable && tick && count_q == `COUNT_MAX);
endmodule // pwm_channel

// ===== hdl/four_channel_pwm.sv
// Four-channel PWM block with its register file on a classic Wishbone slave.
// Assumes a 10 MHz core_clk, synchronous active-high reset, 32-bit Wishbone.
// How it works
// - Four independent channels, zero to three, each drive their own output.
// - Each channel has a 10-bit readable and writable start count.
// - Each channel has a 10-bit readable and writable flip point.
// - Each channel's live 10-bit count is readable; writes to it are ignored.
// - One shared 12-bit setup register holds enables, clock selects and phase.
// - Channels zero to three drive port pins twenty-six to twenty-nine.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "pwm_map.svh"
module four_channel_pwm
  import pwm_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int PRESCALE = `PRESCALE_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic port_pin_twenty_six,
  output logic port_pin_twenty_seven,
  output logic port_pin_twenty_eight,
  output logic port_pin_twenty_nine
);
  count_t channel_start_count_q [CHANNELS];
  count_t channel_flip_point_q [CHANNELS];
  count_t channel_count_readback [CHANNELS];
  logic [11:0] shared_channel_setup_q;
  logic [CHANNELS-1:0] waves;
  logic [7:0] prescale_q;
  logic slow_tick;
  bus_state_t bus_q;
  logic req;

  // Finds the channel index for a per-channel register, or -1 if none.
  function automatic int chan_of(input logic [7:0] adr);
    if (adr < 8'(CHANNELS * 16)) begin
      return int'(adr[7:4]);
    end else begin
      return -1;
    end
  endfunction

  // Prescaler gives the slow counting clock that a channel may select.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescale_q <= 8'h00;
    end else if (ce) begin
      prescale_q <= (prescale_q == 8'(PRESCALE - 1)) ? 8'h00 : prescale_q + 8'h01;
    end
  end
  assign slow_tick = (prescale_q == 8'h00);

  assign req = wb_cyc_i && wb_stb_i && bus_q == BUS_IDLE;

  // Bus handshake: ack one cycle after the request, then one idle cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_q <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else if (ce) begin
      case (bus_q)
        BUS_IDLE: begin
          if (req) begin
            bus_q <= BUS_ACK;
            wb_ack_o <= 1'b1;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_DONE;
          wb_ack_o <= 1'b0;
        end
        BUS_DONE: begin
          bus_q <= BUS_IDLE;
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // Register writes land at the request edge; count readback has no write path.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shared_channel_setup_q <= `SETUP_RESET;
      for (int i = 0; i < CHANNELS; i++) begin
        channel_start_count_q[i] <= `START_RESET;
        channel_flip_point_q[i] <= `FLIP_RESET;
      end
    end else if (ce && req && wb_we_i) begin
      if (wb_adr_i == `OFF_SETUP) begin
        if (wb_sel_i[0]) shared_channel_setup_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) shared_channel_setup_q[11:8] <= wb_dat_i[11:8];
      end else if (chan_of(wb_adr_i) >= 0 && wb_adr_i[3:0] == `OFF_START) begin
        if (wb_sel_i[0]) channel_start_count_q[chan_of(wb_adr_i)][7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) channel_start_count_q[chan_of(wb_adr_i)][9:8] <= wb_dat_i[9:8];
      end else if (chan_of(wb_adr_i) >= 0 && wb_adr_i[3:0] == `OFF_FLIP) begin
        if (wb_sel_i[0]) channel_flip_point_q[chan_of(wb_adr_i)][7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) channel_flip_point_q[chan_of(wb_adr_i)][9:8] <= wb_dat_i[9:8];
      end
    end
  end

  // Read data is captured with the ack; unmapped addresses read zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && req) begin
      if (wb_adr_i == `OFF_SETUP) begin
        wb_dat_o <= {20'h00000, shared_channel_setup_q};
      end else if (chan_of(wb_adr_i) >= 0 && wb_adr_i[3:0] == `OFF_START) begin
        wb_dat_o <= {22'h000000, channel_start_count_q[chan_of(wb_adr_i)]};
      end else if (chan_of(wb_adr_i) >= 0 && wb_adr_i[3:0] == `OFF_FLIP) begin
        wb_dat_o <= {22'h000000, channel_flip_point_q[chan_of(wb_adr_i)]};
      end else if (chan_of(wb_adr_i) >= 0 && wb_adr_i[3:0] == `OFF_COUNT) begin
        wb_dat_o <= {22'h000000, channel_count_readback[chan_of(wb_adr_i)]};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // One channel instance per channel, each taking its own bit of every setup field.
  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
      pwm_channel u_chan (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .enable(shared_channel_setup_q[`SETUP_EN_LSB + g]),
        .tick(shared_channel_setup_q[`SETUP_CLK_LSB + g] ? slow_tick : 1'b1),
        .invert(shared_channel_setup_q[`SETUP_PHASE_LSB + g]),
        .start_count(channel_start_count_q[g]),
        .flip_point(channel_flip_point_q[g]),
        .count_q(channel_count_readback[g]),
        .wave_q(waves[g])
      );
    end
  endgenerate

  // Pins take the channel waves through one more register stage.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_pin_twenty_six <= 1'b0;
      port_pin_twenty_seven <= 1'b0;
      port_pin_twenty_eight <= 1'b0;
      port_pin_twenty_nine <= 1'b0;
    end else if (ce) begin
      port_pin_twenty_six <= waves[0];
      port_pin_twenty_seven <= waves[1];
      port_pin_twenty_eight <= waves[2];
      port_pin_twenty_nine <= waves[3];
    end
  end

  // Bus handshake checks: a one-cycle ack, one cycle after the taken request.
  ack_once_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
  ack_time_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req |=> wb_ack_o) else $error("ack not one cycle after request");

  // Register write checks, for whole words and for a single byte lane.
  setup_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && wb_we_i && wb_adr_i == `OFF_SETUP && wb_sel_i == 4'hf
    |=> shared_channel_setup_q == $past(wb_dat_i[11:0])) else $error("setup write lost");
  setup_lane_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && wb_we_i && wb_adr_i == `OFF_SETUP && wb_sel_i == 4'h2
    |=> shared_channel_setup_q[7:0] == $past(shared_channel_setup_q[7:0])
    && shared_channel_setup_q[11:8] == $past(wb_dat_i[11:8]))
    else $error("setup lane write wrong");
  start_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && wb_we_i && wb_adr_i == `OFF_START && wb_sel_i == 4'hf
    |=> channel_start_count_q[0] == $past(wb_dat_i[9:0])) else $error("start write lost");
  flip_wr_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && wb_we_i && wb_adr_i == `OFF_FLIP && wb_sel_i == 4'hf
    |=> channel_flip_point_q[0] == $past(wb_dat_i[9:0])) else $error("flip write lost");
  count_ro_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && wb_we_i && wb_adr_i == `OFF_COUNT |=> $stable(channel_start_count_q[0])
    && $stable(channel_flip_point_q[0])) else $error("count write had effect");

  // Readback checks: read data stands with the ack and carries the register.
  rd_setup_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && !wb_we_i && wb_adr_i == `OFF_SETUP
    |=> wb_dat_o == {20'h00000, $past(shared_channel_setup_q)})
    else $error("setup readback wrong");
  rd_start_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && !wb_we_i && wb_adr_i == `OFF_START
    |=> wb_dat_o[9:0] == $past(channel_start_count_q[0])) else $error("start readback wrong");
  rd_flip_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && !wb_we_i && wb_adr_i == `OFF_FLIP
    |=> wb_dat_o[9:0] == $past(channel_flip_point_q[0])) else $error("flip readback wrong");
  rd_count_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && !wb_we_i && wb_adr_i == `OFF_COUNT
    |=> wb_dat_o[9:0] == $past(channel_count_readback[0])) else $error("count readback wrong");
  rd_unmapped_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && req && !wb_we_i && wb_adr_i > `OFF_SETUP |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Pin checks: each pin follows its own channel wave one cycle later.
  pin_six_a: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> port_pin_twenty_six == $past(waves[0])) else $error("pin twenty six mismap");
  pin_seven_a: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> port_pin_twenty_seven == $past(waves[1])) else $error("pin twenty seven mismap");
  pin_eight_a: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> port_pin_twenty_eight == $past(waves[2])) else $error("pin twenty eight mismap");
  pin_map_a: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> port_pin_twenty_nine == $past(waves[3])) else $error("pin twenty nine mismap");

  // Clock-enable check: setup and bus state hold while the enable is low.
  freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(shared_channel_setup_q) && $stable(bus_q) && $stable(wb_ack_o))
    else $error("state moved while clock enable low");

  // Covers for the main bus and waveform scenarios.
  wr_c: cover property (@(posedge core_clk) req && wb_we_i);
  rd_c: cover property (@(posedge core_clk) req && !wb_we_i);
  sel_c: cover property (@(posedge core_clk) req && wb_we_i && wb_sel_i != 4'hf);
  pin_c: cover property (@(posedge core_clk) port_pin_twenty_six && port_pin_twenty_eight);
endmodule // four_channel_pwm

// ===== verification/led_load.sv
// LED load model that counts the cycles in which its pin is driven high.
// Assumes the pin is sampled on core_clk and clear restarts the count.
`timescale 1ns/1ns
module led_load (
  input wire logic core_clk,
  input wire logic clear,
  input wire logic pin,
  output int lit_cycles
);
  // Count lit cycles between clears; an unknown pin never counts as lit.
  always @(posedge core_clk) begin
    if (clear) begin
      lit_cycles <= 0;
    end else if (pin === 1'b1) begin
      lit_cycles <= lit_cycles + 1;
    end
  end
endmodule // led_load

// ===== verification/test_four_channel_pwm.sv
// Self-checking bench: registers over Wishbone, channel waves into four LED loads.
// Assumes led_load.sv and the hdl files are compiled before it.
`timescale 1ns/1ns
`include "pwm_map.svh"
module test_four_channel_pwm;
  logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic clear = 1'b1;
  logic [3:0] sel = 4'hf, lanes = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, err;
  logic [3:0] pins;
  int lit [4];
  int error_cnt = 0, comparisons = 0, seed = 32'heb54c65a;
  int mdl_start [4], mdl_flip [4], mdl_setup, per, hi, mdl_cnt;
  int exp_q [$];

  four_channel_pwm #(.CHANNELS(4), .PRESCALE(`PRESCALE_DIV)) four_channel_pwm_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .port_pin_twenty_six(pins[0]),
    .port_pin_twenty_seven(pins[1]), .port_pin_twenty_eight(pins[2]),
    .port_pin_twenty_nine(pins[3]));

  // One LED load on each channel pin.
  for (genvar c = 0; c < 4; c++) begin : loads
    led_load led_load_i (.core_clk(core_clk), .clear(clear), .pin(pins[c]),
      .lit_cycles(lit[c]));
  end

  // Clock with a 100 ns period.
  always #50 core_clk = ~core_clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compares a value with its expectation and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    rdat = dat_o;
    chk(err, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Main sequence: reset values, register access, waveforms, then a mid-run reset.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wb(1'b0, 8'(c) * `CH_STRIDE + `OFF_START, 32'h0);
      chk(rdat, {22'h0, `START_RESET});
      wb(1'b0, 8'(c) * `CH_STRIDE + `OFF_FLIP, 32'h0);
      chk(rdat, {22'h0, `FLIP_RESET});
    end
    wb(1'b0, `OFF_SETUP, 32'h0);
    chk(rdat, {20'h0, `SETUP_RESET});
    wb(1'b0, 8'h80, 32'h0);
    chk(rdat, 32'h0);
    $display("Test reset values done");
    mdl_setup = $random(seed) & 32'hfffffff0;
    wb(1'b1, `OFF_SETUP, mdl_setup);
    wb(1'b0, `OFF_SETUP, 32'h0);
    chk(rdat, mdl_setup & 32'hfff);
    // A write on lane one alone must leave the low setup bits untouched.
    lanes = 4'h2;
    wb(1'b1, `OFF_SETUP, 32'h00000abc);
    lanes = 4'hf;
    wb(1'b0, `OFF_SETUP, 32'h0);
    chk(rdat, (mdl_setup & 32'h0ff) | 32'ha00);
    for (int c = 0; c < 4; c++) begin
      mdl_start[c] = $random(seed);
      mdl_flip[c] = $random(seed);
      wb(1'b1, 8'(c) * `CH_STRIDE + `OFF_START, mdl_start[c]);
      wb(1'b1, 8'(c) * `CH_STRIDE + `OFF_FLIP, mdl_flip[c]);
      wb(1'b1, 8'(c) * `CH_STRIDE + `OFF_COUNT, $random(seed));
      wb(1'b0, 8'(c) * `CH_STRIDE + `OFF_START, 32'h0);
      chk(rdat, mdl_start[c] & 32'h3ff);
      wb(1'b0, 8'(c) * `CH_STRIDE + `OFF_FLIP, 32'h0);
      chk(rdat, mdl_flip[c] & 32'h3ff);
      wb(1'b0, 8'(c) * `CH_STRIDE + `OFF_COUNT, 32'h0);
      chk(rdat, mdl_start[c] & 32'h3ff);
    end
    $display("Test register access done");
    for (int c = 0; c < 4; c++) begin
      mdl_start[c] = 1000;
      mdl_flip[c] = (c == 2) ? 1020 : 1010;
      wb(1'b1, 8'(c) * `CH_STRIDE + `OFF_START, mdl_start[c]);
      wb(1'b1, 8'(c) * `CH_STRIDE + `OFF_FLIP, mdl_flip[c]);
    end
    wb(1'b1, `OFF_SETUP, 32'h247);
    repeat (400) @(posedge core_clk);
    wb(1'b0, `OFF_COUNT, 32'h0);
    chk(rdat >= 1000 && rdat <= 1023, 32'h1);
    // With the enable low for 20 cycles, the next read is still three steps on.
    mdl_cnt = rdat;
    ce <= 1'b0;
    repeat (20) @(posedge core_clk);
    ce <= 1'b1;
    wb(1'b0, `OFF_COUNT, 32'h0);
    for (int k = 0; k < 3; k++) begin
      mdl_cnt = (mdl_cnt == 1023) ? mdl_start[0] : mdl_cnt + 1;
    end
    chk(rdat, mdl_cnt);
    @(posedge core_clk);
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    repeat (384) @(posedge core_clk);
    @(negedge core_clk);
    for (int c = 0; c < 4; c++) begin
      per = 1024 - mdl_start[c];
      hi = 1023 - mdl_flip[c];
      if (c == 1) hi = per - hi;
      if (c == 2) per = per * `PRESCALE_DIV;
      if (c == 2) hi = hi * `PRESCALE_DIV;
      if (c == 3) hi = 0;
      chk(lit[c], hi * (384 / per));
    end
    $display("Test waveforms done");
    // A second reset in mid-run must bring back the reset values and idle pins.
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    exp_q.push_back(`START_RESET);
    exp_q.push_back(`FLIP_RESET);
    exp_q.push_back(`SETUP_RESET);
    exp_q.push_back(`START_RESET);
    wb(1'b0, `OFF_START, 32'h0);
    chk(rdat, exp_q.pop_front());
    wb(1'b0, `OFF_FLIP, 32'h0);
    chk(rdat, exp_q.pop_front());
    wb(1'b0, `OFF_SETUP, 32'h0);
    chk(rdat, exp_q.pop_front());
    wb(1'b0, `OFF_COUNT, 32'h0);
    chk(rdat, exp_q.pop_front());
    chk(pins, 32'h0);
    $display("Test mid-run reset done");
    complete_run();
  end
endmodule // test_four_channel_pwm
